// >>> rtl/acc_fifo.sv
// Sample queue storage with simultaneous push and pop
`timescale 1ns/10ps
`default_nettype none
module acc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    assign rdata = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= wdata;
        end
    end

    // Caller guarantees no push when full unless it pops in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : acc_fifo
`default_nettype wire

// >>> rtl/acc_pkg.sv
// Shared constants, register map and carrier types of the motion sensor readout
`default_nettype none
package acc_pkg;
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int DOZE_FASTEST_HZ = 8;
    localparam int DOZE_BASE_CYCLES = CLK_FREQ_HZ / DOZE_FASTEST_HZ;
    localparam int FIFO_DEPTH = 32;
    localparam int RAW_W = 13;
    localparam int OUT_W = 16;
    localparam logic [4:0] BASE_BITS = 5'h0a;

    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h2d;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h2e;
    localparam logic [7:0] ADDR_INTERRUPT_ROUTING = 8'h2f;
    localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h30;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h31;
    localparam logic [7:0] ADDR_X_SAMPLE_LOW = 8'h32;
    localparam logic [7:0] ADDR_X_SAMPLE_HIGH = 8'h33;
    localparam logic [7:0] ADDR_Y_SAMPLE_LOW = 8'h34;
    localparam logic [7:0] ADDR_Y_SAMPLE_HIGH = 8'h35;
    localparam logic [7:0] ADDR_Z_SAMPLE_LOW = 8'h36;
    localparam logic [7:0] ADDR_Z_SAMPLE_HIGH = 8'h37;
    localparam logic [7:0] ADDR_QUEUE_CONTROL = 8'h38;
    localparam logic [7:0] ADDR_QUEUE_STATE = 8'h39;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] INT_USED_MASK = 8'h9b;
    localparam int INT_READY_BIT = 7;
    localparam int INT_ACT_BIT = 4;
    localparam int INT_INACT_BIT = 3;
    localparam int INT_WMARK_BIT = 1;
    localparam int INT_OVER_BIT = 0;

    localparam int PWR_LINK_BIT = 5;
    localparam int PWR_AUTO_BIT = 4;
    localparam int PWR_MEASURE_BIT = 3;
    localparam int PWR_SLEEP_BIT = 2;
    localparam int PWR_RATE_LSB = 0;
    localparam logic [7:0] PWR_USED_MASK = 8'h3f;

    localparam int FMT_SELFTEST_BIT = 7;
    localparam int FMT_SPI3_BIT = 6;
    localparam int FMT_INVERT_BIT = 5;
    localparam int FMT_FULLRES_BIT = 3;
    localparam int FMT_JUSTIFY_BIT = 2;
    localparam int FMT_RANGE_LSB = 0;
    localparam logic [7:0] FMT_USED_MASK = 8'hef;

    localparam int Q_MODE_LSB = 6;
    localparam int Q_TRIG_BIT = 5;
    localparam int Q_SAMPLES_LSB = 0;
    localparam int STAT_EVENT_BIT = 7;

    typedef enum logic [1:0] {
        Q_BYPASS = 2'h0,
        Q_FIFO = 2'h1,
        Q_STREAM = 2'h2,
        Q_TRIGGER = 2'h3
    } acc_qmode_type;

    // Gray order along standby -> measure -> asleep
    typedef enum logic [1:0] {
        ST_STANDBY = 2'h0,
        ST_MEASURE = 2'h1,
        ST_ASLEEP = 2'h3
    } acc_power_type;

    typedef struct packed {
        logic [OUT_W-1:0] z;
        logic [OUT_W-1:0] y;
        logic [OUT_W-1:0] x;
    } acc_sample_type;

    typedef struct packed {
        logic signed [RAW_W-1:0] z;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] x;
    } acc_raw_type;

    typedef struct packed {
        logic wr;
        logic last;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acc_req_type;
endpackage : acc_pkg
`default_nettype wire

// >>> rtl/acc_readout.sv
// Motion sensor control, output formatting, sample queue and interrupt pins
`timescale 1ns/10ps
`default_nettype none
module acc_readout
    import acc_pkg::*;
#(
    parameter int DOZE_BASE = acc_pkg::DOZE_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic reg_req_valid,
    input wire acc_pkg::acc_req_type reg_req,
    output logic reg_busy,
    output logic reg_done,
    output logic [7:0] reg_rdata,
    input wire logic raw_valid,
    input wire acc_pkg::acc_raw_type raw_sample,
    input wire logic act_detect,
    input wire logic inact_detect,
    output logic sense_strobe,
    output logic self_test_force,
    output logic spi_three_wire,
    output acc_pkg::acc_power_type power_state,
    output logic irq_pin_a,
    output logic irq_pin_b
);
    import acc_pkg::*;

    // Clip and place one axis
    function automatic logic [OUT_W-1:0] fmt_axis(input logic signed [RAW_W-1:0] raw,
            input logic [1:0] range, input logic full, input logic left);
        logic signed [OUT_W-1:0] v;
        logic signed [OUT_W-1:0] lim;
        logic [4:0] w;
        v = OUT_W'(raw);
        w = BASE_BITS;
        if (full) begin
            w = BASE_BITS + {3'h0, range};
        end else begin
            v = v >>> range;
        end
        lim = 16'sh1 <<< (w - 5'h1);
        if (v > lim - 16'sh1) begin
            v = lim - 16'sh1;
        end else if (v < -lim) begin
            v = -lim;
        end
        if (left) begin
            v = v <<< (5'h10 - w);
        end
        return v;
    endfunction : fmt_axis

    // ---------------- Link side: request capture and answer ----------------
    acc_req_type req_hold;
    logic req_tgl;
    logic ack_tgl;
    logic ack_s;
    logic ack_last;
    logic [7:0] resp_data;
    logic ack_edge;

    acc_sync #(.WIDTH(1)) u_ack_sync (
        .clk(link_clk),
        .resetn(resetn),
        .d(ack_tgl),
        .q(ack_s)
    );

    assign ack_edge = ack_s ^ ack_last;

    // Hold register stays still while the core reads it, so words cross safely
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            req_hold <= '0;
            req_tgl <= 1'b0;
            reg_busy <= 1'b0;
            reg_done <= 1'b0;
            reg_rdata <= 8'h00;
            ack_last <= 1'b0;
        end else begin
            ack_last <= ack_s;
            reg_done <= ack_edge;
            if (ack_edge) begin
                reg_rdata <= resp_data;
                reg_busy <= 1'b0;
            end else if (reg_req_valid && !reg_busy) begin
                req_hold <= reg_req;
                req_tgl <= ~req_tgl;
                reg_busy <= 1'b1;
            end
        end
    end

    // ---------------- Core side ----------------
    logic req_s;
    logic req_last;
    logic req_edge;
    logic [7:0] pwr;
    logic [7:0] ien;
    logic [7:0] imap;
    logic [7:0] fmt;
    logic [7:0] qctl;
    logic is_data;
    logic data_pending;
    logic data_done;
    logic flags_read;

    acc_sync #(.WIDTH(1)) u_req_sync (
        .clk(clk),
        .resetn(resetn),
        .d(req_tgl),
        .q(req_s)
    );

    assign req_edge = req_s ^ req_last;
    assign is_data = req_hold.addr >= ADDR_X_SAMPLE_LOW && req_hold.addr <= ADDR_Z_SAMPLE_HIGH;
    assign flags_read = req_edge && !req_hold.wr && req_hold.addr == ADDR_INTERRUPT_FLAGS;
    // Pop only when the transfer ends, so a burst in a queue mode sees one consistent sample
    assign data_done = req_edge && req_hold.last && (data_pending || (is_data && !req_hold.wr));

    acc_qmode_type qmode;
    logic [4:0] samples;
    assign qmode = acc_qmode_type'(qctl[Q_MODE_LSB +: 2]);
    assign samples = qctl[Q_SAMPLES_LSB +: 5];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_last <= 1'b0;
            data_pending <= 1'b0;
            pwr <= CTRL_RESET;
            ien <= CTRL_RESET;
            imap <= CTRL_RESET;
            fmt <= CTRL_RESET;
            qctl <= CTRL_RESET;
        end else begin
            req_last <= req_s;
            if (req_edge) begin
                data_pending <= !req_hold.last && (data_pending || (is_data && !req_hold.wr));
            end
            if (req_edge && req_hold.wr) begin
                unique case (req_hold.addr)
                    ADDR_POWER_CONTROL: pwr <= req_hold.wdata & PWR_USED_MASK;
                    ADDR_INTERRUPT_ENABLE: ien <= req_hold.wdata & INT_USED_MASK;
                    ADDR_INTERRUPT_ROUTING: imap <= req_hold.wdata & INT_USED_MASK;
                    ADDR_OUTPUT_FORMAT: fmt <= req_hold.wdata & FMT_USED_MASK;
                    ADDR_QUEUE_CONTROL: qctl <= req_hold.wdata;
                    default: ;
                endcase
            end
        end
    end

    assign self_test_force = fmt[FMT_SELFTEST_BIT];
    assign spi_three_wire = fmt[FMT_SPI3_BIT];

    // ---------------- Power states and linked detection ----------------
    logic linked;
    logic act_armed;
    logic act_ok;
    logic inact_ok;
    logic auto_doze;
    acc_power_type next_state;
    logic [31:0] doze_cnt;
    logic [31:0] doze_period;
    logic doze_tick;

    assign linked = pwr[PWR_LINK_BIT] && ien[INT_ACT_BIT] && ien[INT_INACT_BIT];
    assign act_ok = act_detect && power_state != ST_STANDBY && (!linked || act_armed);
    assign inact_ok = inact_detect && power_state == ST_MEASURE && !(linked && act_armed);

    always_comb begin
        if (!pwr[PWR_MEASURE_BIT]) begin
            next_state = ST_STANDBY;
        end else if (pwr[PWR_SLEEP_BIT] || auto_doze) begin
            next_state = ST_ASLEEP;
        end else begin
            next_state = ST_MEASURE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_state <= ST_STANDBY;
            act_armed <= 1'b0;
            auto_doze <= 1'b0;
        end else begin
            power_state <= next_state;
            if (!linked) begin
                act_armed <= 1'b0;
            end else if (inact_ok) begin
                act_armed <= 1'b1;
            end else if (act_ok) begin
                act_armed <= 1'b0;
            end
            if (!pwr[PWR_LINK_BIT] || !pwr[PWR_AUTO_BIT] || !pwr[PWR_MEASURE_BIT] || act_ok) begin
                auto_doze <= 1'b0;
            end else if (inact_ok) begin
                auto_doze <= 1'b1;
            end
        end
    end

    assign doze_period = 32'(DOZE_BASE) << pwr[PWR_RATE_LSB +: 2];
    assign doze_tick = power_state == ST_ASLEEP && doze_cnt == doze_period - 32'h1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doze_cnt <= 32'h0;
            sense_strobe <= 1'b0;
        end else begin
            doze_cnt <= (power_state != ST_ASLEEP || doze_tick) ? 32'h0 : doze_cnt + 32'h1;
            sense_strobe <= (power_state == ST_MEASURE && raw_valid) || doze_tick;
        end
    end

    // ---------------- Output data and sample queue ----------------
    acc_sample_type fresh_sample;
    acc_sample_type out_sample;
    acc_sample_type head;
    logic [5:0] count;
    logic take;
    logic full;
    logic push;
    logic trim;
    logic refill;
    logic out_valid;
    logic fresh;
    logic overrun;
    logic trig_seen;
    logic act_flag;
    logic inact_flag;
    logic ready_now;
    logic wm_now;
    logic [7:0] flags;
    logic pin_a_raw;
    logic pin_b_raw;

    always_comb begin
        fresh_sample.x = fmt_axis(raw_sample.x, fmt[FMT_RANGE_LSB +: 2], fmt[FMT_FULLRES_BIT],
            fmt[FMT_JUSTIFY_BIT]);
        fresh_sample.y = fmt_axis(raw_sample.y, fmt[FMT_RANGE_LSB +: 2], fmt[FMT_FULLRES_BIT],
            fmt[FMT_JUSTIFY_BIT]);
        fresh_sample.z = fmt_axis(raw_sample.z, fmt[FMT_RANGE_LSB +: 2], fmt[FMT_FULLRES_BIT],
            fmt[FMT_JUSTIFY_BIT]);
    end

    assign take = power_state == ST_MEASURE && raw_valid;
    assign full = count == 6'(FIFO_DEPTH);

    always_comb begin
        push = 1'b0;
        trim = 1'b0;
        unique case (qmode)
            Q_BYPASS: ;
            Q_FIFO: push = take && !full;
            Q_STREAM: begin
                push = take;
                trim = take && full;
            end
            Q_TRIGGER: begin
                if (trig_seen) begin
                    push = take && !full;
                end else begin
                    push = take;
                    trim = take && count != 6'h0 && count >= {1'b0, samples};
                end
            end
        endcase
    end

    assign refill = qmode != Q_BYPASS && count != 6'h0 && (!out_valid || data_done);

    acc_fifo #(.WIDTH($bits(acc_sample_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .push(push),
        .wdata(fresh_sample),
        .pop(refill || trim),
        .rdata(head),
        .count(count)
    );

    // Ready is hidden while asleep even if an entry is still held
    assign ready_now = power_state != ST_ASLEEP && (qmode == Q_BYPASS ? fresh : out_valid);
    assign wm_now = samples == 5'h0 || (qmode != Q_BYPASS && count >= {1'b0, samples});
    assign flags = {ready_now, 2'h0, act_flag, inact_flag, 1'b0, wm_now, overrun};
    assign pin_a_raw = |(flags & ien & ~imap);
    assign pin_b_raw = |(flags & ien & imap);

    // Set wins over clear for every sticky flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_sample <= '0;
            out_valid <= 1'b0;
            fresh <= 1'b0;
            overrun <= 1'b0;
            trig_seen <= 1'b0;
            act_flag <= 1'b0;
            inact_flag <= 1'b0;
        end else begin
            if (qmode == Q_BYPASS && take) begin
                out_sample <= fresh_sample;
            end else if (refill) begin
                out_sample <= head;
            end
            out_valid <= refill || (out_valid && !data_done && qmode != Q_BYPASS);
            fresh <= (qmode == Q_BYPASS && take) || (fresh && !data_done);
            overrun <= (take && ((qmode == Q_BYPASS && fresh && !data_done) || (qmode != Q_BYPASS
                && full))) || (overrun && !data_done);
            if (qmode == Q_TRIGGER && (qctl[Q_TRIG_BIT] ? pin_b_raw : pin_a_raw)) begin
                trig_seen <= 1'b1;
            end else if (req_edge && req_hold.wr && req_hold.addr == ADDR_QUEUE_CONTROL) begin
                trig_seen <= 1'b0;
            end
            act_flag <= act_ok || (act_flag && !flags_read);
            inact_flag <= inact_ok || (inact_flag && !flags_read);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end else begin
            irq_pin_a <= pin_a_raw ^ fmt[FMT_INVERT_BIT];
            irq_pin_b <= pin_b_raw ^ fmt[FMT_INVERT_BIT];
        end
    end

    // ---------------- Register read answer ----------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp_data <= 8'h00;
            ack_tgl <= 1'b0;
        end else if (req_edge) begin
            ack_tgl <= ~ack_tgl;
            unique case (req_hold.addr)
                ADDR_POWER_CONTROL: resp_data <= pwr;
                ADDR_INTERRUPT_ENABLE: resp_data <= ien;
                ADDR_INTERRUPT_ROUTING: resp_data <= imap;
                ADDR_INTERRUPT_FLAGS: resp_data <= flags;
                ADDR_OUTPUT_FORMAT: resp_data <= fmt;
                ADDR_X_SAMPLE_LOW: resp_data <= out_sample.x[7:0];
                ADDR_X_SAMPLE_HIGH: resp_data <= out_sample.x[15:8];
                ADDR_Y_SAMPLE_LOW: resp_data <= out_sample.y[7:0];
                ADDR_Y_SAMPLE_HIGH: resp_data <= out_sample.y[15:8];
                ADDR_Z_SAMPLE_LOW: resp_data <= out_sample.z[7:0];
                ADDR_Z_SAMPLE_HIGH: resp_data <= out_sample.z[15:8];
                ADDR_QUEUE_CONTROL: resp_data <= qctl;
                ADDR_QUEUE_STATE: resp_data <= {trig_seen, 1'b0, count};
                default: resp_data <= 8'h00;
            endcase
        end
    end

    // ---------------- Checks ----------------
    a_standby_follows_bit: assert property (@(posedge clk) disable iff (!resetn)
        !pwr[PWR_MEASURE_BIT] |=> power_state == ST_STANDBY)
        else $error("Not in standby with measure bit clear");
    a_sleep_no_store: assert property (@(posedge clk) disable iff (!resetn)
        power_state == ST_ASLEEP |-> !flags[INT_READY_BIT]
        ##1 count <= $past(count) && (!fresh || $past(fresh)))
        else $error("Sample stored while asleep");
    a_auto_doze_gate: assert property (@(posedge clk) disable iff (!resetn)
        !pwr[PWR_AUTO_BIT] |=> !auto_doze)
        else $error("Auto doze active with its bit clear");
    a_doze_enters_sleep: assert property (@(posedge clk) disable iff (!resetn)
        inact_ok && pwr[PWR_LINK_BIT] && pwr[PWR_AUTO_BIT] && pwr[PWR_MEASURE_BIT] && !act_ok
        ##1 pwr[PWR_MEASURE_BIT] |=> power_state == ST_ASLEEP)
        else $error("Inactivity did not put device to sleep");
    a_pin_route_a: assert property (@(posedge clk) disable iff (!resetn)
        |(flags & ien & ~imap) && !fmt[FMT_INVERT_BIT] ##1 !fmt[FMT_INVERT_BIT] |-> irq_pin_a)
        else $error("Routed interrupt missing on pin a");
    a_pin_idle_level: assert property (@(posedge clk) disable iff (!resetn)
        (flags & ien & imap) == 8'h00 && $stable(fmt) |=> irq_pin_b == $past(fmt[FMT_INVERT_BIT]))
        else $error("Idle level of pin b wrong for polarity");
    a_wmark_zero: assert property (@(posedge clk) disable iff (!resetn)
        samples == 5'h0 |-> flags[INT_WMARK_BIT])
        else $error("Watermark not set with zero samples");
    a_fifo_stops_full: assert property (@(posedge clk) disable iff (!resetn)
        qmode == Q_FIFO && full |=> count == 6'(FIFO_DEPTH) || $past(refill))
        else $error("Full queue changed without a read");
    a_link_order: assert property (@(posedge clk) disable iff (!resetn)
        linked && !act_armed |-> !act_ok)
        else $error("Activity taken before inactivity in linked mode");
    a_flag_read_clears: assert property (@(posedge clk) disable iff (!resetn)
        flags_read && !act_ok |=> !act_flag)
        else $error("Activity flag survived its read");
    c_enter_sleep: cover property (@(posedge clk) disable iff (!resetn)
        power_state == ST_MEASURE ##1 power_state == ST_ASLEEP);
    c_queue_full: cover property (@(posedge clk) disable iff (!resetn) full && data_done);
    c_trigger_seen: cover property (@(posedge clk) disable iff (!resetn) $rose(trig_seen));
    c_link_answer: cover property (@(posedge link_clk) disable iff (!resetn) reg_done);
endmodule : acc_readout
`default_nettype wire

// >>> rtl/acc_sync.sv
// Two-stage level synchroniser
`timescale 1ns/10ps
`default_nettype none
module acc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage <= '0;
            q <= '0;
        end else begin
            stage <= d;
            q <= stage;
        end
    end
endmodule : acc_sync
`default_nettype wire

// >>> verification/acc_host.sv
// Host model driving the register link
`timescale 1ns/10ps
`default_nettype none
module acc_host
    import acc_pkg::*;
(
    input wire logic link_clk,
    input wire logic reg_busy,
    input wire logic reg_done,
    input wire logic [7:0] reg_rdata,
    output logic reg_req_valid,
    output acc_pkg::acc_req_type reg_req,
    output logic hung
);
    import acc_pkg::*;
    initial begin
        reg_req_valid = 1'b0;
        reg_req = '0;
        hung = 1'b0;
    end
    // Request held until the edge that sees busy low; released fields invert so stale data shows
    // Holding it up to the done edge would be taken again as a second request
    task automatic xfer(input logic w, l, input logic [7:0] a, d, output logic [7:0] r);
        int n;
        @(posedge link_clk);
        reg_req_valid <= 1'b1;
        reg_req <= acc_req_type'({w, l, a, d});
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (reg_busy !== 1'b0 && n < 40);
        reg_req_valid <= 1'b0;
        reg_req <= ~reg_req;
        do begin
            @(posedge link_clk);
            n++;
        end while (reg_done !== 1'b1 && n < 40);
        if (n >= 40) hung = 1'b1;
        r = reg_rdata;
    endtask : xfer
endmodule : acc_host
`default_nettype wire

// >>> verification/acc_readout_bench.sv
// Self-checking bench for the sensor readout block
`timescale 1ns/10ps
`default_nettype none
module acc_readout_bench;
    import acc_pkg::*;
    logic clk, link_clk, resetn, raw_valid, act_detect, inact_detect, hung, rq_v, busy, done;
    logic stb, stf, spi3, pin_a, pin_b;
    logic [7:0] rdata, v;
    acc_req_type rq;
    acc_raw_type raw;
    acc_power_type pst;
    int err_total, checks_done, cycles;
    acc_readout #(.DOZE_BASE(20)) dut (.clk(clk), .resetn(resetn), .link_clk(link_clk),
        .reg_req_valid(rq_v), .reg_req(rq), .reg_busy(busy), .reg_done(done),
        .reg_rdata(rdata), .raw_valid(raw_valid), .raw_sample(raw), .act_detect(act_detect),
        .inact_detect(inact_detect), .sense_strobe(stb), .self_test_force(stf),
        .spi_three_wire(spi3), .power_state(pst), .irq_pin_a(pin_a), .irq_pin_b(pin_b));
    acc_host host (.link_clk(link_clk), .reg_busy(busy), .reg_done(done), .reg_rdata(rdata),
        .reg_req_valid(rq_v), .reg_req(rq), .hung(hung));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, 1'b1, a, d, v);
        repeat (3) @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic l, input logic [7:0] m);
        host.xfer(1'b0, l, a, 8'h00, v);
        v = v & m;
        repeat (3) @(negedge clk);
    endtask : rd
    task automatic smp(input logic [12:0] x, input logic [12:0] y);
        @(negedge clk);
        raw = {13'h0000, y, x};
        raw_valid = 1;
        @(negedge clk);
        raw_valid = 0;
    endtask : smp
    task automatic det(input logic a, input logic i);
        @(negedge clk);
        act_detect = a;
        inact_detect = i;
        @(negedge clk);
        act_detect = 0;
        inact_detect = 0;
        repeat (6) @(negedge clk);
    endtask : det
    task automatic t_reset;
        logic [7:0] ad[5] = '{8'h2d, 8'h2e, 8'h2f, 8'h31, 8'h38};
        foreach (ad[i]) begin
            rd(ad[i], 1'b1, 8'hff);
            chk("reset reg", 8'h00, v);
        end
        rd(8'h30, 1'b1, 8'hff);
        chk("flags", 8'h02, v);
        rd(8'h20, 1'b1, 8'hff);
        chk("unmapped", 8'h00, v);
        chk("power", 8'(ST_STANDBY), 8'(pst));
    endtask : t_reset
    task automatic t_format;
        wr(8'h31, 8'hc0);
        chk("force spi3", 8'h03, {6'h00, stf, spi3});
        wr(8'h31, 8'h20);
        chk("pins idle", 8'h03, {6'h00, pin_a, pin_b});
        wr(8'h2e, 8'h02);
        chk("pin a", 8'h01, {6'h00, pin_a, pin_b});
        wr(8'h2f, 8'h02);
        chk("pin b", 8'h02, {6'h00, pin_a, pin_b});
        wr(8'h31, 8'h0b);
    endtask : t_format
    task automatic t_bypass;
        logic [7:0] e[6] = '{8'hf3, 8'hff, 8'h00, 8'h04, 8'h00, 8'h00};
        wr(8'h2d, 8'h08);
        chk("measure", 8'(ST_MEASURE), 8'(pst));
        smp(13'h1ff3, 13'h0400);
        rd(8'h30, 1'b1, 8'h80);
        chk("ready set", 8'h80, v);
        foreach (e[i]) begin
            rd(8'h32 + 8'(i), i == 5, 8'hff);
            chk("data byte", e[i], v);
        end
        rd(8'h30, 1'b1, 8'h80);
        chk("ready clear", 8'h00, v);
    endtask : t_bypass
    task automatic t_queue;
        wr(8'h38, 8'h42);
        for (int i = 0; i < 34; i++) smp(13'(i), 13'h0000);
        rd(8'h39, 1'b1, 8'hff);
        chk("entries full", 8'h20, v);
        rd(8'h30, 1'b1, 8'h03);
        chk("wmark overrun", 8'h03, v);
        for (int i = 0; i < 6; i++) rd(8'h32 + 8'(i), i == 5, 8'hff);
        rd(8'h39, 1'b1, 8'hff);
        chk("entries pop", 8'h1f, v);
    endtask : t_queue
    task automatic t_stream;
        wr(8'h38, 8'h82);
        smp(13'h0028, 13'h0000);
        smp(13'h0029, 13'h0000);
        for (int i = 0; i < 12; i++) begin
            rd(8'h32 + 8'(i % 6), i % 6 == 5, 8'hff);
            if (i % 6 == 0) chk("stream oldest", (i == 0) ? 8'h01 : 8'h03, v);
        end
        wr(8'h38, 8'hc4);
        rd(8'h39, 1'b1, 8'hff);
        chk("trigger a idle", 8'h1e, v);
        wr(8'h38, 8'he4);
        rd(8'h39, 1'b1, 8'hff);
        chk("trigger b seen", 8'h9e, v);
    endtask : t_stream
    // Doze strobes in a window of 80 core cycles; exact for any phase
    task automatic count_strobes(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        repeat (80) begin
            @(negedge clk);
            if (stb === 1'b1) n++;
        end
        chk("doze strobes", e, n);
    endtask : count_strobes
    task automatic t_sleep;
        wr(8'h38, 8'h00);
        wr(8'h2e, 8'h18);
        wr(8'h2d, 8'h38);
        det(1'b0, 1'b1);
        chk("auto sleep", 8'(ST_ASLEEP), 8'(pst));
        rd(8'h30, 1'b1, 8'h08);
        chk("inact flag", 8'h08, v);
        rd(8'h30, 1'b1, 8'h08);
        chk("inact clear", 8'h00, v);
        det(1'b1, 1'b0);
        chk("wake", 8'(ST_MEASURE), 8'(pst));
        wr(8'h2d, 8'h0c);
        chk("manual sleep", 8'(ST_ASLEEP), 8'(pst));
        count_strobes(8'h04);
        wr(8'h2d, 8'h0d);
        count_strobes(8'h02);
        wr(8'h2d, 8'h00);
        chk("standby", 8'(ST_STANDBY), 8'(pst));
    endtask : t_sleep
    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Bounded run so a stuck link cannot hang the bench
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000 || hung === 1'b1) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        resetn = 0;
        raw_valid = 0;
        raw = '0;
        act_detect = 0;
        inact_detect = 0;
        repeat (4) @(negedge clk);
        resetn = 1;
        repeat (4) @(negedge clk);
        t_reset();
        t_format();
        t_bypass();
        t_queue();
        t_stream();
        t_sleep();
        give_verdict();
    end
endmodule : acc_readout_bench
`default_nettype wire
